// [spwc_top.sv]
// module: system pins, wake indicator, speed strap and led/gpio pins
// What this block does
// - reset pin low resets all state
// - internal power-on reset when pin floats
// - writes ignored until first read
// - assert wake indicator on enabled wake event while asleep
// - wake indicator polarity and drive selectable
// - only host write wakes device
// - latch speed strap at reset release
// - each pin push-pull, open-drain or input
// - led-selected pins always drive open-drain
// - speed led high only at 10Mbs
// - link led low while link, no blink
// - activity pulses link led high 80ms
// - then low at least 80ms before repeat
// - strap 0: 10, half, no autoneg; 1: 100, half, autoneg
// - duplex led low in full duplex
`timescale 1ns/100ps
module spwc_top #(
  parameter int BLINK_CYCLES = spwc_pkg::BLINK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reset_in_low,
  input wire logic reset_in_driven,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host strobes seen on the pins
  input wire logic chip_select_low,
  input wire logic write_strobe_low,
  // phy/mac status
  input wire logic speed_strap,
  input wire logic phy_speed100,
  input wire logic phy_link_up,
  input wire logic phy_activity,
  input wire logic phy_full_duplex,
  input wire logic phy_autoneg_busy,
  input wire logic wake_event,
  // general-purpose / led pins
  input wire logic [2:0] indicator_leds_in,
  output logic [2:0] indicator_leds_out,
  output logic [2:0] indicator_leds_oe_low,
  // wake indicator pin
  output logic wake_indicator_out,
  output logic wake_indicator_oe_low,
  // status and interrupt
  output logic asleep,
  output logic irq
);
  typedef struct packed {
    logic [4:0] por_cnt;
    logic por_done;
    logic strap_taken;
    logic strap;
    logic read_seen;
    logic asleep;
    logic [10:0] pin_cfg;
    logic [2:0] pin_out;
    logic [2:0] wake_cfg;
    logic wake_latched;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic link_prev;
    logic host_wr_prev;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] pins_o;
    logic [2:0] pins_oe_low;
    logic wake_o;
    logic wake_oe_low;
    logic irq;
  } spwc_top_s;
  spwc_top_s r_ff;
  spwc_top_s nxt_r;

  logic rst_any;
  logic [2:0] led_val;
  logic host_wr;
  logic wake_level;
  logic aw_take;
  logic w_take;
  logic ar_take;
  spwc_led_if led_bus ();

  // reset pin only counts when driven; otherwise the power-on counter covers it
  assign rst_any = sys_rst | (reset_in_driven & ~reset_in_low);

  assign led_bus.link_up = phy_link_up;
  assign led_bus.activity = phy_activity;

  spwc_blink #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_blink (
    .ref_clk(ref_clk),
    .rst_any(rst_any),
    .led(led_bus)
  );

  always_comb begin
    // speed led low at 100, autoneg, or no cable
    led_val[0] = ~phy_speed100 & phy_link_up & ~phy_autoneg_busy;
    led_val[1] = led_bus.link_led_low;
    led_val[2] = ~(phy_full_duplex & phy_link_up);
  end

  assign host_wr = ~chip_select_low & ~write_strobe_low;
  assign aw_take = s_axi_awvalid & ~r_ff.aw_got & ~r_ff.bvalid;
  assign w_take = s_axi_wvalid & ~r_ff.w_got & ~r_ff.bvalid;
  assign ar_take = s_axi_arvalid & ~r_ff.rvalid;
  assign wake_level = r_ff.wake_latched ^ ~r_ff.wake_cfg[spwc_pkg::WAKE_POL_BIT];

  always_comb begin
    logic wr_go;
    logic wr_ok;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [2:0] ev;
    logic [1:0] mode;
    logic [3:0] ws;
    wr_go = 1'b0;
    wr_ok = 1'b0;
    wa = 8'h00;
    wd = 32'h0000_0000;
    ev = 3'h0;
    mode = 2'h0;
    ws = 4'h0;
    nxt_r = r_ff;
    // power-on counter and strap capture after release
    if (!r_ff.por_done) begin
      nxt_r.por_cnt = r_ff.por_cnt + 5'h01;
      if (r_ff.por_cnt == 5'(spwc_pkg::POR_CYCLES - 1)) begin
        nxt_r.por_done = 1'b1;
      end
    end
    if (!r_ff.strap_taken) begin
      nxt_r.strap = speed_strap;
      nxt_r.strap_taken = 1'b1;
    end
    // axi write
    if (aw_take) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = s_axi_wdata;
      // strobes travel with the data beat, which may arrive before the address
      nxt_r.wstrb = s_axi_wstrb;
    end
    wa = r_ff.aw_got ? r_ff.awaddr : s_axi_awaddr;
    wd = r_ff.w_got ? r_ff.wdata : s_axi_wdata;
    ws = r_ff.w_got ? r_ff.wstrb : s_axi_wstrb;
    wr_go = (r_ff.aw_got | aw_take) & (r_ff.w_got | w_take) & ~r_ff.bvalid;
    if (wr_go) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
      nxt_r.bvalid = 1'b1;
      // space above ADDR_POWER is refused even while writes are still disarmed
      nxt_r.bresp = (wa > spwc_pkg::ADDR_POWER) ? spwc_pkg::RESP_SLVERR : spwc_pkg::RESP_OKAY;
      // a sleeping device ignores all bus writes; only the pin-level host write wakes it
      wr_ok = r_ff.read_seen & ~r_ff.asleep & r_ff.por_done;
      if (wr_ok && (&ws || wa == spwc_pkg::ADDR_INT_STAT)) begin
        case (wa)
          spwc_pkg::ADDR_PATTERN: begin
          end
          spwc_pkg::ADDR_PIN_CFG: nxt_r.pin_cfg = wd[10:0];
          spwc_pkg::ADDR_PIN_OUT: nxt_r.pin_out = wd[2:0];
          spwc_pkg::ADDR_WAKE_CFG: nxt_r.wake_cfg = wd[2:0];
          spwc_pkg::ADDR_INT_MASK: nxt_r.irq_mask = wd[2:0];
          spwc_pkg::ADDR_INT_STAT: nxt_r.irq_stat = r_ff.irq_stat & ~wd[2:0];
          spwc_pkg::ADDR_POWER: begin
            nxt_r.asleep = wd[0];
            nxt_r.read_seen = ~wd[0];
          end
          default: nxt_r.bresp = spwc_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (r_ff.bvalid && s_axi_bready) begin
      nxt_r.bvalid = 1'b0;
    end
    // axi read; a read arms writes
    if (ar_take) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = spwc_pkg::RESP_OKAY;
      nxt_r.rdata = 32'h0000_0000;
      nxt_r.read_seen = 1'b1;
      case (s_axi_araddr)
        spwc_pkg::ADDR_PATTERN: nxt_r.rdata = spwc_pkg::TEST_PATTERN;
        spwc_pkg::ADDR_PIN_CFG: nxt_r.rdata[10:0] = r_ff.pin_cfg;
        spwc_pkg::ADDR_PIN_OUT: nxt_r.rdata[2:0] = r_ff.pin_out;
        spwc_pkg::ADDR_PIN_IN: nxt_r.rdata[2:0] = indicator_leds_in;
        spwc_pkg::ADDR_WAKE_CFG: nxt_r.rdata[2:0] = r_ff.wake_cfg;
        spwc_pkg::ADDR_STATUS: nxt_r.rdata[5:0] = {r_ff.read_seen, r_ff.asleep,
          r_ff.strap, phy_full_duplex, phy_speed100, r_ff.strap};
        spwc_pkg::ADDR_INT_STAT: nxt_r.rdata[2:0] = r_ff.irq_stat;
        spwc_pkg::ADDR_INT_MASK: nxt_r.rdata[2:0] = r_ff.irq_mask;
        spwc_pkg::ADDR_POWER: nxt_r.rdata[0] = r_ff.asleep;
        default: nxt_r.rresp = spwc_pkg::RESP_SLVERR;
      endcase
      // autoneg default follows strap
      if (s_axi_araddr == spwc_pkg::ADDR_STATUS) begin
        nxt_r.rdata[spwc_pkg::ST_AUTONEG] = r_ff.strap;
        nxt_r.rdata[spwc_pkg::ST_ASLEEP] = r_ff.asleep;
        nxt_r.rdata[spwc_pkg::ST_READ_SEEN] = r_ff.read_seen;
      end
    end
    if (r_ff.rvalid && s_axi_rready) begin
      nxt_r.rvalid = 1'b0;
    end
    // pin-level host write wakes the device; data does not matter
    nxt_r.host_wr_prev = host_wr;
    if (r_ff.asleep && host_wr && !r_ff.host_wr_prev) begin
      nxt_r.asleep = 1'b0;
      ev[spwc_pkg::IRQ_HOST_WAKE] = 1'b1;
    end
    // wake event raises IRQ_WAKE, and the indicator only while asleep; it never clears asleep
    if (wake_event && r_ff.wake_cfg[spwc_pkg::WAKE_EN_BIT]) begin
      nxt_r.wake_latched = 1'b1;
      ev[spwc_pkg::IRQ_WAKE] = 1'b1;
    end
    if (!r_ff.asleep || !r_ff.wake_cfg[spwc_pkg::WAKE_EN_BIT]) begin
      nxt_r.wake_latched = 1'b0;
    end
    nxt_r.link_prev = phy_link_up;
    ev[spwc_pkg::IRQ_LINK_CHANGE] = phy_link_up ^ r_ff.link_prev;
    // set wins over a clear in the same cycle
    nxt_r.irq_stat = nxt_r.irq_stat | ev;
    nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
    // pin drivers
    for (int i = 0; i < 3; i++) begin
      mode = r_ff.pin_cfg[spwc_pkg::PIN_MODE_LSB + 2*i +: 2];
      if (r_ff.pin_cfg[spwc_pkg::PIN_LED_LSB + i]) begin
        nxt_r.pins_o[i] = 1'b0;
        nxt_r.pins_oe_low[i] = led_val[i];
      end else begin
        case (mode)
          spwc_pkg::MODE_PUSH_PULL: begin
            nxt_r.pins_o[i] = r_ff.pin_out[i];
            nxt_r.pins_oe_low[i] = 1'b0;
          end
          spwc_pkg::MODE_OPEN_DRAIN: begin
            nxt_r.pins_o[i] = 1'b0;
            nxt_r.pins_oe_low[i] = r_ff.pin_out[i];
          end
          default: begin
            nxt_r.pins_o[i] = 1'b0;
            nxt_r.pins_oe_low[i] = 1'b1;
          end
        endcase
      end
    end
    // wake pin drive type
    if (r_ff.wake_cfg[spwc_pkg::WAKE_OD_BIT]) begin
      nxt_r.wake_o = 1'b0;
      nxt_r.wake_oe_low = wake_level;
    end else begin
      nxt_r.wake_o = wake_level;
      nxt_r.wake_oe_low = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      r_ff <= '0;
      r_ff.pin_cfg <= spwc_pkg::PIN_CFG_RESET;
      r_ff.pins_oe_low <= 3'h7;
      r_ff.wake_oe_low <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign s_axi_awready = ~r_ff.aw_got & ~r_ff.bvalid;
  assign s_axi_wready = ~r_ff.w_got & ~r_ff.bvalid;
  assign s_axi_bvalid = r_ff.bvalid;
  assign s_axi_bresp = r_ff.bresp;
  assign s_axi_arready = ~r_ff.rvalid;
  assign s_axi_rvalid = r_ff.rvalid;
  assign s_axi_rdata = r_ff.rdata;
  assign s_axi_rresp = r_ff.rresp;
  assign indicator_leds_out = r_ff.pins_o;
  assign indicator_leds_oe_low = r_ff.pins_oe_low;
  assign wake_indicator_out = r_ff.wake_o;
  assign wake_indicator_oe_low = r_ff.wake_oe_low;
  assign asleep = r_ff.asleep;
  assign irq = r_ff.irq;
endmodule // spwc_top

// [spwc_pkg.sv]
// package: register map, field layout, reset values and timing for the system pin block
package spwc_pkg;
  // register byte offsets (aligned words)
  localparam logic [7:0] ADDR_PATTERN = 8'h00;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h04;
  localparam logic [7:0] ADDR_PIN_OUT = 8'h08;
  localparam logic [7:0] ADDR_PIN_IN = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
  localparam logic [7:0] ADDR_POWER = 8'h20;
  // fixed test pattern (value arbitrary)
  localparam logic [31:0] TEST_PATTERN = 32'h8765_4321;
  // pin config: per pin 2-bit mode at [2i+1:2i], led select at bit 8+i
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_LED_LSB = 8;
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h2;
  localparam logic [10:0] PIN_CFG_RESET = 11'h000;
  // wake config bits
  localparam int WAKE_EN_BIT = 0;
  localparam int WAKE_POL_BIT = 1;
  localparam int WAKE_OD_BIT = 2;
  // status bits
  localparam int ST_STRAP = 0;
  localparam int ST_SPEED100 = 1;
  localparam int ST_FULL_DUPLEX = 2;
  localparam int ST_AUTONEG = 3;
  localparam int ST_ASLEEP = 4;
  localparam int ST_READ_SEEN = 5;
  // interrupt bits
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_HOST_WAKE = 1;
  localparam int IRQ_LINK_CHANGE = 2;
  localparam int IRQ_WIDTH = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BLINK_MS = 80;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  localparam int POR_CYCLES = 16;
endpackage

// [spwc_led_if.sv]
// interface: link status and led levels between top and led timer
`timescale 1ns/100ps
interface spwc_led_if;
  logic link_up;
  logic activity;
  logic link_led_low;
  logic timer_busy;
  modport timer (input link_up, input activity, output link_led_low, output timer_busy);
  modport top (output link_up, output activity, input link_led_low, input timer_busy);
endinterface

// [spwc_blink.sv]
// module: link/activity led on-off timing
`timescale 1ns/100ps
module spwc_blink #(
  parameter int BLINK_CYCLES = spwc_pkg::BLINK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_any,
  // link status in, led level out
  spwc_led_if.timer led
);
  typedef enum logic [2:0] {
    SPWC_IDLE = 3'b001,
    SPWC_OFF = 3'b010,
    SPWC_ON = 3'b100
  } spwc_blink_e;
  typedef struct packed {
    spwc_blink_e st;
    logic [31:0] cnt;
    logic pend;
    logic led_low;
  } spwc_blink_s;
  spwc_blink_s r_ff;
  spwc_blink_s nxt_r;

  always_comb begin
    nxt_r = r_ff;
    if (led.activity && led.link_up) begin
      nxt_r.pend = 1'b1;
    end
    case (r_ff.st)
      SPWC_IDLE: begin
        nxt_r.led_low = led.link_up;
        if (led.link_up && (led.activity || r_ff.pend)) begin
          nxt_r.st = SPWC_OFF;
          nxt_r.cnt = 32'h0000_0000;
          nxt_r.pend = 1'b0;
          nxt_r.led_low = 1'b0;
        end
      end
      SPWC_OFF: begin
        nxt_r.led_low = 1'b0;
        nxt_r.cnt = r_ff.cnt + 32'h0000_0001;
        if (r_ff.cnt == 32'(BLINK_CYCLES - 1)) begin
          nxt_r.st = SPWC_ON;
          nxt_r.cnt = 32'h0000_0000;
          nxt_r.led_low = 1'b1;
        end
      end
      SPWC_ON: begin
        // low for at least the full interval before another blink
        nxt_r.led_low = led.link_up;
        nxt_r.cnt = r_ff.cnt + 32'h0000_0001;
        if (r_ff.cnt == 32'(BLINK_CYCLES - 1)) begin
          nxt_r.st = SPWC_IDLE;
          nxt_r.cnt = 32'h0000_0000;
          // latched activity restarts the blink with no extra lit cycle
          if (r_ff.pend || led.activity) begin
            nxt_r.st = SPWC_OFF;
            nxt_r.pend = 1'b0;
            nxt_r.led_low = 1'b0;
          end
        end
      end
      default: begin
        nxt_r.st = SPWC_IDLE;
      end
    endcase
    // dropping the link abandons any blink
    if (!led.link_up) begin
      nxt_r.st = SPWC_IDLE;
      nxt_r.cnt = 32'h0000_0000;
      nxt_r.pend = 1'b0;
      nxt_r.led_low = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      r_ff <= '{st: SPWC_IDLE, cnt: 32'h0000_0000, pend: 1'b0, led_low: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // unlit (high) level out is the inverse sense of led_low flag
  assign led.link_led_low = ~r_ff.led_low;
  assign led.timer_busy = (r_ff.st != SPWC_IDLE);
endmodule // spwc_blink

// [spwc_checker.sv]
// checker: bus answer, reset and wake relations at the system pin block ports
`timescale 1ns/100ps
module spwc_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reset_in_low,
  input wire logic reset_in_driven,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // pins
  input wire logic chip_select_low,
  input wire logic write_strobe_low,
  input wire logic [2:0] indicator_leds_oe_low,
  input wire logic asleep
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || (reset_in_driven && !reset_in_low));
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // strobe pair goes active from idle while asleep
  sequence host_strobe;
    asleep && (chip_select_low || write_strobe_low) ##1 !(chip_select_low || write_strobe_low);
  endsequence
  AST_PIN_RESET: assert property (disable iff (sys_rst)
    (reset_in_driven && !reset_in_low) |-> (indicator_leds_oe_low == 3'b111 && !asleep
    && !s_axi_bvalid && !s_axi_rvalid)) else $error("state kept under pin reset");
  AST_WR_ANSWER: assert property (wr_take |=> s_axi_bvalid)
    else $error("no write answer");
  AST_WR_UNMAPPED: assert property (wr_take ##0 (s_axi_awaddr > spwc_pkg::ADDR_POWER)
    |=> s_axi_bresp == spwc_pkg::RESP_SLVERR) else $error("unmapped write not refused");
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
    else $error("no read answer");
  AST_RD_PATTERN: assert property (rd_take ##0 (s_axi_araddr == spwc_pkg::ADDR_PATTERN)
    |=> s_axi_rdata == spwc_pkg::TEST_PATTERN) else $error("bad test pattern");
  AST_RD_UNMAPPED: assert property (rd_take ##0 (s_axi_araddr > spwc_pkg::ADDR_POWER)
    |=> s_axi_rresp == spwc_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  AST_HOST_WAKE: assert property (host_strobe |-> ##[1:2] !asleep)
    else $error("host write did not wake");
  AST_STAY_ASLEEP: assert property (asleep && chip_select_low |=> asleep)
    else $error("woke without host write");
endmodule // spwc_checker
bind spwc_top spwc_checker spwc_checker_inst (.ref_clk, .sys_rst, .reset_in_low,
  .reset_in_driven, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .chip_select_low, .write_strobe_low,
  .indicator_leds_oe_low, .asleep);

// [spwc_host_model.sv]
// partner model: host pin strobes and pulled-up led and wake pins
`timescale 1ns/100ps
module spwc_host_model (
  // clock
  input wire logic ref_clk,
  // pins from the block
  input wire logic [2:0] leds_out,
  input wire logic [2:0] leds_oe_low,
  input wire logic wake_out,
  input wire logic wake_oe_low,
  // board drive onto the pins
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  // host strobes and resolved pin levels
  output logic chip_select_low = 1'b1,
  output logic write_strobe_low = 1'b1,
  output logic [2:0] leds_level,
  output logic wake_level
);
  // released pins float to the pull-up unless the board drives them, never to the last driven value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      leds_level[i] = !leds_oe_low[i] ? leds_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
    wake_level = !wake_oe_low ? wake_out : 1'b1;
  end
  // one-cycle host write strobe pair; address and data lines not modelled
  task automatic pin_write();
    @(posedge ref_clk);
    chip_select_low <= 1'b0;
    write_strobe_low <= 1'b0;
    @(posedge ref_clk);
    chip_select_low <= 1'b1;
    write_strobe_low <= 1'b1;
  endtask
endmodule // spwc_host_model

// [system_pins_led_wake_control_bench.sv]
// testbench: bus, pin modes, led timing, wake and reset of the system pin block
`timescale 1ns/100ps
module system_pins_led_wake_control_bench;
  localparam int BLINK = 20;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reset_in_low = 1'b1, reset_in_driven = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, speed_strap = 1, phy_speed100 = 0, phy_link_up = 0;
  logic phy_activity = 0, phy_full_duplex = 0, phy_autoneg_busy = 0, wake_event = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] ext_en = '0, ext_val = '0, lvl, indicator_leds_out, indicator_leds_oe_low;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic chip_select_low, write_strobe_low, wake_indicator_out, wake_indicator_oe_low;
  logic asleep, irq, wake_lvl;
  logic [15:0] lfsr_st = 16'h004b;
  int err_total = 0, n_checks = 0;
  int mreg [int];
  bit m_seen = 0, m_asleep = 0;
  always #10 ref_clk = ~ref_clk;
  spwc_top #(.BLINK_CYCLES(BLINK)) spwc_top_inst (.ref_clk, .sys_rst, .reset_in_low,
    .reset_in_driven, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chip_select_low, .write_strobe_low, .speed_strap,
    .phy_speed100, .phy_link_up, .phy_activity, .phy_full_duplex, .phy_autoneg_busy,
    .wake_event, .indicator_leds_in(lvl), .indicator_leds_out, .indicator_leds_oe_low,
    .wake_indicator_out, .wake_indicator_oe_low, .asleep, .irq);
  spwc_host_model spwc_host_model_inst (.ref_clk, .leds_out(indicator_leds_out),
    .leds_oe_low(indicator_leds_oe_low), .wake_out(wake_indicator_out),
    .wake_oe_low(wake_indicator_oe_low), .ext_en, .ext_val, .chip_select_low,
    .write_strobe_low, .leds_level(lvl), .wake_level(wake_lvl));
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // registered outputs need a couple of edges after the bus answer
  task automatic settle();
    cyc(2);
    @(negedge ref_clk);
  endtask
  // ready is a function of flops, so sampling at the falling edge is race free
  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] rsp;
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(negedge ref_clk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_hit) s_axi_awvalid <= 0;
      if (w_hit) s_axi_wvalid <= 0;
      n++;
    end while (!b_hit && n < 100);
    s_axi_bready <= 0;
    check("bresp", rsp, er);
    if (er == spwc_pkg::RESP_OKAY && m_seen && !m_asleep) begin
      if (a == spwc_pkg::ADDR_POWER) begin
        m_asleep = d[0];
        m_seen = !d[0];
      end else if (a == spwc_pkg::ADDR_INT_STAT) begin
        mreg[a] = mreg[a] & ~d;
      end else begin
        mreg[a] = d;
      end
    end
  endtask
  task automatic axi_rd(logic [7:0] a, logic [31:0] exp, logic [31:0] msk, logic [1:0] er);
    logic ar_hit, r_hit;
    logic [31:0] rd;
    logic [1:0] rsp;
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(negedge ref_clk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_hit) s_axi_arvalid <= 0;
      n++;
    end while (!r_hit && n < 100);
    s_axi_rready <= 0;
    check("rresp", rsp, er);
    check("rdata", rd & msk, exp & msk);
    if (er == spwc_pkg::RESP_OKAY) m_seen = 1;
  endtask
  task automatic pulse_act();
    @(posedge ref_clk);
    phy_activity <= 1;
    @(posedge ref_clk);
    phy_activity <= 0;
  endtask
  // length of the current run of the link led level, capped at 200
  task automatic run_len(logic v, output int n);
    n = 0;
    while (n < 200) begin
      @(negedge ref_clk);
      if (lvl[1] !== v) break;
      n++;
    end
  endtask
  initial begin
    #(20 * 60_000);
    err_total++;
    final_report();
  end
  initial begin
    int n;
    logic [2:0] wc, ex, m;
    for (int a = 0; a <= 32; a += 4) mreg[a] = 0;
    cyc(16);
    sys_rst <= 0;
    cyc(20);
    axi_wr(spwc_pkg::ADDR_PIN_CFG, 32'h0000_0015, spwc_pkg::RESP_OKAY);
    axi_rd(spwc_pkg::ADDR_STATUS, 32'h0000_0009, 32'h0000_000d, 0);
    axi_rd(spwc_pkg::ADDR_PIN_CFG, 0, 32'h0000_07ff, 0);
    axi_rd(spwc_pkg::ADDR_PATTERN, spwc_pkg::TEST_PATTERN, '1, 0);
    axi_rd(8'h24, 0, 0, spwc_pkg::RESP_SLVERR);
    axi_wr(8'h24, 32'h0000_0001, spwc_pkg::RESP_SLVERR);
    // pin0 push-pull, pin1 open-drain, pin2 input driven by the board
    axi_wr(spwc_pkg::ADDR_PIN_CFG, 32'h0000_0009, 0);
    ext_en <= 3'b100;
    repeat (6) begin
      lfsr_st = lfsr_next(lfsr_st);
      axi_wr(spwc_pkg::ADDR_PIN_OUT, {29'h0, lfsr_st[2:0]}, 0);
      ext_val <= lfsr_st[5:3];
      settle();
      ex = {lfsr_st[5], lfsr_st[1:0]};
      check("pin_lvl", lvl, ex);
      check("pin_oe", indicator_leds_oe_low, {1'b1, lfsr_st[1], 1'b0});
      axi_rd(spwc_pkg::ADDR_PIN_IN, ex, 32'h0000_0004, 0);
    end
    ext_en <= 0;
    axi_wr(spwc_pkg::ADDR_PIN_CFG, 32'h0000_0700, 0);
    for (int i = 0; i < 16; i++) begin
      {phy_link_up, phy_speed100, phy_autoneg_busy, phy_full_duplex} <= i[3:0];
      cyc(4);
      @(negedge ref_clk);
      ex = {!i[0], !i[3], i[3] && !i[2] && !i[1]};
      m = i[3] ? 3'b111 : 3'b001;
      check("led_lvl", lvl & m, ex & m);
      check("led_od", indicator_leds_oe_low, lvl);
    end
    pulse_act();
    run_len(1'b0, n);
    fork
      begin
        cyc(4);
        pulse_act();
      end
    join_none
    run_len(1'b1, n);
    check("blink_hi", n + 1, BLINK);
    run_len(1'b0, n);
    check("blink_lo", n + 1, BLINK);
    run_len(1'b1, n);
    check("blink_rep", n + 1, BLINK);
    run_len(1'b0, n);
    check("blink_idle", n, 200);
    for (int k = 0; k < 2; k++) begin
      wc = k ? 3'b101 : 3'b011;
      axi_rd(spwc_pkg::ADDR_STATUS, 0, 0, 0);
      axi_wr(spwc_pkg::ADDR_INT_STAT, 32'h0000_0007, 0);
      axi_wr(spwc_pkg::ADDR_WAKE_CFG, {29'h0, wc}, 0);
      axi_wr(spwc_pkg::ADDR_INT_MASK, 32'h0000_0001, 0);
      axi_wr(spwc_pkg::ADDR_POWER, 32'h0000_0001, 0);
      axi_wr(spwc_pkg::ADDR_PIN_OUT, 32'h0000_0005, 0);
      settle();
      check("wake_idle", {wake_lvl, wake_indicator_oe_low}, {!wc[1], wc[2]});
      @(posedge ref_clk);
      wake_event <= 1;
      @(posedge ref_clk);
      wake_event <= 0;
      settle();
      check("wake_on", {wake_lvl, wake_indicator_oe_low}, {wc[1], 1'b0});
      check("still_asleep", {asleep, irq}, 2'b11);
      spwc_host_model_inst.pin_write();
      m_asleep = 0;
      settle();
      check("woken", {asleep, wake_lvl}, {1'b0, !wc[1]});
      axi_rd(spwc_pkg::ADDR_PIN_OUT, mreg[spwc_pkg::ADDR_PIN_OUT], 7, 0);
      axi_rd(spwc_pkg::ADDR_INT_STAT, 3, 3, 0);
      axi_wr(spwc_pkg::ADDR_INT_STAT, 32'h0000_0001, 0);
      settle();
      check("irq_clr", irq, 0);
      axi_wr(spwc_pkg::ADDR_INT_MASK, 32'h0000_0002, 0);
      settle();
      check("irq_mask", irq, 1);
      axi_wr(spwc_pkg::ADDR_INT_STAT, 32'h0000_0002, 0);
      settle();
      check("irq_clr2", irq, 0);
    end
    axi_wr(spwc_pkg::ADDR_PIN_CFG, 32'h0000_0015, 0);
    reset_in_driven <= 0;
    reset_in_low <= 0;
    cyc(5);
    axi_rd(spwc_pkg::ADDR_PIN_CFG, mreg[spwc_pkg::ADDR_PIN_CFG], 32'h0000_07ff, 0);
    reset_in_driven <= 1;
    settle();
    check("pin_rst_oe", indicator_leds_oe_low, 3'b111);
    @(posedge ref_clk);
    reset_in_low <= 1;
    speed_strap <= 0;
    m_seen = 0;
    mreg[spwc_pkg::ADDR_PIN_CFG] = 0;
    cyc(20);
    axi_wr(spwc_pkg::ADDR_PIN_CFG, 32'h0000_0015, 0);
    axi_rd(spwc_pkg::ADDR_PIN_CFG, 0, 32'h0000_07ff, 0);
    axi_rd(spwc_pkg::ADDR_STATUS, 0, 32'h0000_0009, 0);
    final_report();
  end
endmodule // system_pins_led_wake_control_bench
